// File: hdl/fpl_pkg.sv
package fpl_pkg;

	// ------------------------------------------------------------
	// Register map and bus widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DUMP = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_ERR = 0;
	localparam int CTRL_WARN = 1;
	localparam int CTRL_JOG = 2;
	localparam int CTRL_RUN = 3;
	localparam int CTRL_DEV = 4;
	localparam int CTRL_RECOV = 5;
	localparam int CTRL_TEST = 6;
	localparam int CTRL_DROP = 7;
	localparam int CTRL_BOOTED = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam int DUMP_OK = 0;
	localparam int DUMP_FAIL = 1;
	localparam int STAT_LAMP = 0;
	localparam int STAT_STATE = 5;
	localparam int STAT_ESTOP = 7;
	localparam int STAT_REQ = 8;
	localparam int STAT_PHASE = 9;
	localparam int LAMP_FAULT = 0;
	localparam int LAMP_ESTOP = 1;
	localparam int LAMP_JOG = 2;
	localparam int LAMP_RUN = 3;
	localparam int LAMP_DEV = 4;
	localparam int PIN_TRIG = 0;
	localparam int PIN_ESTOP = 1;
	localparam int PIN_W = 2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int HOLD_MS = 2000;
	localparam int BLINK_HALF_MS = 250;
	localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
	localparam int BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam int CNT_W = 28;

	// Dump sequence states
	typedef enum logic [1:0] {ST_IDLE, ST_DUMP, ST_OK, ST_FAIL} fpl_dump_e;

endpackage

// File: hdl/fpl_tick_if.sv
`timescale 1ns/1ps
interface fpl_tick_if;
	logic phase;
	logic [1:0] pins;

	modport blink_mp (output phase);
	modport sync_mp (output pins);
	modport use_mp (input phase, input pins);
endinterface

// File: hdl/fpl_blink.sv
`timescale 1ns/1ps
module fpl_blink #(
	parameter int unsigned HALF_CYCLES = fpl_pkg::BLINK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	fpl_tick_if.blink_mp tick
);
	logic [fpl_pkg::CNT_W-1:0] cnt_r;
	logic phase_r;
	wire logic wrap = (cnt_r == fpl_pkg::CNT_W'(HALF_CYCLES - 1));

	// Free-running half-period counter; one phase for every lamp
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			phase_r <= 1'b0;
		end else begin
			cnt_r <= wrap ? '0 : cnt_r + 1'b1;
			phase_r <= wrap ? ~phase_r : phase_r;
		end
	end

	assign tick.phase = phase_r;
endmodule

// File: hdl/fpl_sync.sv
`timescale 1ns/1ps
module fpl_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] pins_in,
	fpl_tick_if.sync_mp tick
);
	logic [1:0] meta_r;
	logic [1:0] sync_r;

	// Two-stage synchroniser; only the second stage is visible
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 2'h0;
			sync_r <= 2'h0;
		end else begin
			meta_r <= pins_in;
			sync_r <= meta_r;
		end
	end

	assign tick.pins = sync_r;
endmodule

// File: hdl/fpl_lamps.sv
`timescale 1ns/1ps
// Function
// - Five separate lamp outputs driven
// - Error steady fault, warning blinks, stop steady
// - Jog/test, run, development modes blink lamps
// - Start-up blinks jog, run, development together
// - Trigger press starts status dump once booted and idle
// - Dump in progress blinks three mode lamps
// - Dump success: three lamps on, fault off
// - Dump failure: four lamps on two seconds
// - Recovery: fault, jog, development steady on
// - Supply drop: jog and run steady on
module fpl_lamps #(
	parameter int unsigned HOLD_CYCLES = fpl_pkg::HOLD_CYC,
	parameter int unsigned BLINK_CYCLES = fpl_pkg::BLINK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trigger_in,
	input wire logic estop_in,
	output logic lamp_fault,
	output logic lamp_estop,
	output logic lamp_jog,
	output logic lamp_run,
	output logic lamp_dev,
	output logic dump_start,
	output logic dump_busy
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Word-address match against a register offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	// ------------------------------------------------------------
	// Pin synchroniser and blink phase
	// ------------------------------------------------------------
	fpl_tick_if tick ();

	fpl_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_in({estop_in, trigger_in}),
		.tick(tick)
	);

	fpl_blink #(
		.HALF_CYCLES(BLINK_CYCLES)
	) u_blink (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// Shared blink phase and synchronised pins
	wire logic phase = tick.phase;
	wire logic trig_s = tick.pins[fpl_pkg::PIN_TRIG];
	wire logic estop_s = tick.pins[fpl_pkg::PIN_ESTOP];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Write channel registers
	logic awready_r;
	logic wready_r;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	// Read channel registers
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Control word and dump sequence
	logic [8:0] ctrl_r;
	logic [8:0] ctrl_nxt;
	logic req_r;
	logic trig_d_r;
	logic start_r;
	logic busy_r;
	logic [fpl_pkg::CNT_W-1:0] hold_cnt_r;
	fpl_pkg::fpl_dump_e st_r;
	fpl_pkg::fpl_dump_e st_nxt;

	// Lamp pattern registers
	logic [4:0] lamps_r;
	logic [4:0] lamps_nxt;

	// ------------------------------------------------------------
	// Write channel decode
	// ------------------------------------------------------------
	// Handshakes and register selects
	wire logic aw_hs = s_axi_awvalid & awready_r;
	wire logic w_hs = s_axi_wvalid & wready_r;
	wire logic wr_fire = aw_got_r & w_got_r & ~bvalid_r;
	wire logic wr_ctrl = wr_fire & hit(waddr_r, fpl_pkg::OFF_CTRL);
	wire logic wr_dump = wr_fire & hit(waddr_r, fpl_pkg::OFF_DUMP) & wstrb_r[0];
	wire logic wr_stat = wr_fire & hit(waddr_r, fpl_pkg::OFF_STAT) & wstrb_r[1];
	wire logic wr_mapped = hit(waddr_r, fpl_pkg::OFF_CTRL) | hit(waddr_r, fpl_pkg::OFF_DUMP)
		| hit(waddr_r, fpl_pkg::OFF_STAT);
	wire logic rep_ok = wr_dump & wdata_r[fpl_pkg::DUMP_OK];
	wire logic rep_fail = wr_dump & wdata_r[fpl_pkg::DUMP_FAIL];
	wire logic req_clr = wr_stat & wdata_r[fpl_pkg::STAT_REQ];

	// Byte-lane merge of the control word
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wstrb_r[0]) begin
			ctrl_nxt[7:0] = wdata_r[7:0];
		end
		if (wstrb_r[1]) begin
			ctrl_nxt[8] = wdata_r[8];
		end
	end

	// Address and data phases, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			awready_r <= s_axi_awvalid & ~awready_r & ~aw_got_r & ~bvalid_r;
			wready_r <= s_axi_wvalid & ~wready_r & ~w_got_r & ~bvalid_r;
			if (aw_hs) begin
				waddr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			aw_got_r <= wr_fire ? 1'b0 : (aw_got_r | aw_hs);
			w_got_r <= wr_fire ? 1'b0 : (w_got_r | w_hs);
		end
	end

	// Write response after both phases are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= fpl_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? fpl_pkg::RESP_OKAY : fpl_pkg::RESP_SLVERR;
		end else if (bvalid_r & s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Status flags written by the controller software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= fpl_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	// Read handshake and data select
	wire logic ar_hs = s_axi_arvalid & arready_r;
	wire logic rd_ctrl = hit(s_axi_araddr, fpl_pkg::OFF_CTRL);
	wire logic rd_dump = hit(s_axi_araddr, fpl_pkg::OFF_DUMP);
	wire logic rd_stat = hit(s_axi_araddr, fpl_pkg::OFF_STAT);
	wire logic [31:0] stat_word = {22'h00_0000, phase, req_r, estop_s, st_r, lamps_r};
	wire logic [31:0] rd_word = rd_ctrl ? {23'h00_0000, ctrl_r} : rd_stat ? stat_word : 32'h0000_0000;

	// One read at a time, answered the cycle after the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= fpl_pkg::RESP_OKAY;
		end else begin
			arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
			if (ar_hs) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_word;
				rresp_r <= (rd_ctrl | rd_dump | rd_stat) ? fpl_pkg::RESP_OKAY : fpl_pkg::RESP_SLVERR;
			end else if (rvalid_r & s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Status dump sequence
	// ------------------------------------------------------------
	// Press detection and hold timing
	wire logic booted = ctrl_r[fpl_pkg::CTRL_BOOTED];
	wire logic press = trig_s & ~trig_d_r;
	wire logic accept = press & booted & (st_r == fpl_pkg::ST_IDLE);
	wire logic holding = (st_r == fpl_pkg::ST_OK) | (st_r == fpl_pkg::ST_FAIL);
	wire logic hold_end = holding & (hold_cnt_r == fpl_pkg::CNT_W'(HOLD_CYCLES - 1));

	// Next dump state
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			fpl_pkg::ST_IDLE: begin
				if (accept) begin
					st_nxt = fpl_pkg::ST_DUMP;
				end
			end
			fpl_pkg::ST_DUMP: begin
				if (rep_fail) begin
					st_nxt = fpl_pkg::ST_FAIL;
				end else if (rep_ok) begin
					st_nxt = fpl_pkg::ST_OK;
				end
			end
			fpl_pkg::ST_OK: begin
				if (hold_end) begin
					st_nxt = fpl_pkg::ST_IDLE;
				end
			end
			fpl_pkg::ST_FAIL: begin
				if (hold_end) begin
					st_nxt = fpl_pkg::ST_IDLE;
				end
			end
			default: begin
				st_nxt = fpl_pkg::ST_IDLE;
			end
		endcase
	end

	// State, two-second hold counter, start pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= fpl_pkg::ST_IDLE;
			hold_cnt_r <= '0;
			trig_d_r <= 1'b0;
			start_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			hold_cnt_r <= holding ? hold_cnt_r + 1'b1 : '0;
			trig_d_r <= trig_s;
			start_r <= accept;
			busy_r <= (st_nxt == fpl_pkg::ST_DUMP);
		end
	end

	// Sticky press flag; a new press beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_r <= 1'b0;
		end else begin
			req_r <= accept | (req_r & ~req_clr);
		end
	end

	// ------------------------------------------------------------
	// Lamp pattern
	// ------------------------------------------------------------
	// Control flags feeding the lamp tiers
	wire logic err = ctrl_r[fpl_pkg::CTRL_ERR];
	wire logic warn = ctrl_r[fpl_pkg::CTRL_WARN];
	wire logic recov = ctrl_r[fpl_pkg::CTRL_RECOV];
	wire logic drop = ctrl_r[fpl_pkg::CTRL_DROP];
	wire logic jog_m = ctrl_r[fpl_pkg::CTRL_JOG] | ctrl_r[fpl_pkg::CTRL_TEST];

	// Mode lamps {dev, run, jog} for each tier
	wire logic [2:0] t1_mode = holding ? 3'b111 : {3{phase}};
	wire logic [2:0] t2_mode = recov ? 3'b101 : 3'b011;
	wire logic [2:0] t4_mode = {ctrl_r[fpl_pkg::CTRL_DEV], ctrl_r[fpl_pkg::CTRL_RUN], jog_m} & {3{phase}};
	wire logic tier1 = (st_r != fpl_pkg::ST_IDLE) | ~booted;
	wire logic tier2 = recov | drop;
	wire logic [2:0] mode_sel = tier1 ? t1_mode : tier2 ? t2_mode : t4_mode;

	// Fault lamp chain
	wire logic t3_fault = err | (warn & phase);
	wire logic t2_fault = recov | t3_fault;
	wire logic fault_sel = (st_r == fpl_pkg::ST_FAIL) ? 1'b1 : (st_r == fpl_pkg::ST_OK) ? 1'b0 : t2_fault;

	// Emergency stop lamp follows the synchronised input
	assign lamps_nxt = {mode_sel, estop_s, fault_sel};

	// Registered lamps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lamps_r <= 5'h00;
		end else begin
			lamps_r <= lamps_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Bus channel outputs
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Lamp and dump outputs
	assign lamp_fault = lamps_r[fpl_pkg::LAMP_FAULT];
	assign lamp_estop = lamps_r[fpl_pkg::LAMP_ESTOP];
	assign lamp_jog = lamps_r[fpl_pkg::LAMP_JOG];
	assign lamp_run = lamps_r[fpl_pkg::LAMP_RUN];
	assign lamp_dev = lamps_r[fpl_pkg::LAMP_DEV];
	assign dump_start = start_r;
	assign dump_busy = busy_r;

endmodule

// File: testbench/fpl_lamps_assertions.sv
`timescale 1ns/1ps
// --------
// Port checks of the lamp block
// --------
module fpl_lamps_assertions #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic estop_in,
	input wire logic lamp_estop,
	input wire logic lamp_jog,
	input wire logic lamp_run,
	input wire logic lamp_dev,
	input wire logic dump_start,
	input wire logic dump_busy
);
	localparam int HEND = HOLD_CYCLES + 4;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus answers stand until taken, awready is a one-cycle pulse, reads are answered within two cycles
	chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	// Dump sequence and lamp patterns
	chk_start_pulse: assert property (dump_start |=> !dump_start)
		else $error("dump_start longer than one cycle");
	chk_start_busy: assert property (dump_start |-> ##[0:1] dump_busy)
		else $error("dump did not begin");
	chk_dump_blink: assert property (dump_busy && $past(dump_busy) |-> lamp_jog == lamp_run && lamp_run == lamp_dev)
		else $error("mode lamps out of step in dump");
	chk_hold_steady: assert property ($fell(dump_busy) |-> ##1 (lamp_jog && lamp_run && lamp_dev) [*8])
		else $error("mode lamps not steady after dump");
	chk_hold_ends: assert property ($fell(dump_busy) |-> ##[2:HEND] !(lamp_jog && lamp_run && lamp_dev))
		else $error("result hold did not end");
	chk_estop_on: assert property (estop_in [*5] |-> lamp_estop)
		else $error("stop lamp not lit");
	chk_estop_off: assert property (!estop_in [*5] |-> !lamp_estop)
		else $error("stop lamp lit without stop");
	cover property (dump_start);
	cover property ($fell(dump_busy));
	cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind fpl_lamps fpl_lamps_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_fpl_lamps_assertions (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.estop_in(estop_in), .lamp_estop(lamp_estop), .lamp_jog(lamp_jog), .lamp_run(lamp_run),
	.lamp_dev(lamp_dev), .dump_start(dump_start), .dump_busy(dump_busy));

// File: testbench/fpl_panel_model.sv
`timescale 1ns/1ps
// --------
// Panel model: trigger switch and stop button
// --------
module fpl_panel_model (
	input wire logic aclk,
	input wire logic push,
	input wire logic stop,
	output logic trigger_in,
	output logic estop_in
);
	// Contacts follow the request one clock later
	always @(posedge aclk) begin
		trigger_in <= push;
		estop_in <= stop;
	end
endmodule

// File: testbench/front_panel_status_lamps_test.sv
`timescale 1ns/1ps
module front_panel_status_lamps_test;
	// --------
	// Signals
	// --------
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, push, stop, trig, estop;
	logic lf, le, lj, lr, ld, dstart, dbusy;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [33:0] q[$];
	logic [16:0] rnd;
	logic [8:0] cv [11] = '{9'h101, 9'h102, 9'h104, 9'h108, 9'h110, 9'h140, 9'h120, 9'h180, 9'h1A0, 9'h105, 9'h11A};
	logic [4:0] con [11] = '{5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 5'h0C, 5'h15, 5'h01, 5'h00};
	logic [4:0] cbl [11] = '{5'h00, 5'h01, 5'h04, 5'h08, 5'h10, 5'h04, 5'h00, 5'h00, 5'h00, 5'h04, 5'h19};
	int n_fail, tests_run;
	int bcnt;
	logic ph_m;
	localparam int BLINK = 4;

	fpl_lamps #(.HOLD_CYCLES(20), .BLINK_CYCLES(BLINK)) u_fpl_lamps (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_in(trig), .estop_in(estop),
		.lamp_fault(lf), .lamp_estop(le), .lamp_jog(lj), .lamp_run(lr), .lamp_dev(ld),
		.dump_start(dstart), .dump_busy(dbusy));
	fpl_panel_model u_fpl_panel_model (.aclk(aclk), .push(push), .stop(stop), .trigger_in(trig), .estop_in(estop));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// --------
	// Helpers
	// --------
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction

	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude;
		if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 60) begin
			n_fail++;
			conclude();
		end
	endtask

	// Blink phase model: toggles every BLINK cycles from reset release
	always @(posedge aclk) begin
		if (!aresetn) begin
			bcnt <= 0;
			ph_m <= 1'b0;
		end else begin
			bcnt <= (bcnt == BLINK - 1) ? 0 : bcnt + 1;
			if (bcnt == BLINK - 1) ph_m <= ~ph_m;
		end
	end

	// Each bus answer is compared with the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready) chk("bresp", {bresp, 32'h0}, q.size() ? q.pop_front() : '1);
		if (rvalid && rready) chk("rdata", {rresp, rdata}, q.size() ? q.pop_front() : '1);
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		q.push_back({r, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		while ((awvalid || wvalid || !bvalid) && n < 60) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		tmo(n);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		while ((arvalid || !rvalid) && n < 60) begin
			@(posedge aclk);
			if (arready) begin
				arvalid <= 1'b0;
				// Note taken at the capture edge; a status word carries the model's phase
				q.push_back({r, d | ((a == fpl_pkg::OFF_STAT) ? {22'h0, ph_m, 9'h0} : 32'h0)});
			end
			n++;
		end
		rready <= 1'b0;
		tmo(n);
	endtask

	// Watch the lamps for 12 clocks: steady, lit and shared phase
	task automatic look(input logic [4:0] on, input logic [4:0] bl);
		logic [4:0] a, o, l;
		logic ph;
		a = 5'h1F;
		o = 5'h00;
		ph = 1'b1;
		repeat (12) begin
			@(posedge aclk);
			l = {ld, lr, lj, le, lf};
			a = a & l;
			o = o | l;
			if ((l & bl) != 5'h00 && (l & bl) != bl) ph = 1'b0;
		end
		chk("lamps on", {29'h0, a}, {29'h0, on});
		chk("lamps lit", {29'h0, o}, {29'h0, on | bl});
		chk("blink phase", {33'h0, ph}, 34'h1);
	endtask

	task automatic press;
		int n;
		@(posedge aclk);
		push <= 1'b1;
		n = 0;
		while (!dstart && n < 60) begin
			@(posedge aclk);
			n++;
		end
		@(posedge aclk);
		chk("busy", {33'h0, dbusy}, 34'h1);
		push <= 1'b0;
		tmo(n);
	endtask

	// --------
	// Main sequence
	// --------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, push, stop} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		n_fail = 0;
		tests_run = 0;
		rnd = 17'h1537A;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		look(5'h00, 5'h1C);
		rd(fpl_pkg::OFF_CTRL, 32'h0, fpl_pkg::RESP_OKAY);
		rd(8'h0C, 32'h0, fpl_pkg::RESP_SLVERR);
		wr(8'h0C, 32'h1FF, fpl_pkg::RESP_SLVERR);
		push <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("busy", {33'h0, dbusy}, 34'h0);
		push <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			wr(fpl_pkg::OFF_CTRL, {15'h0, rnd}, fpl_pkg::RESP_OKAY);
			rd(fpl_pkg::OFF_CTRL, {23'h0, rnd[8:0]}, fpl_pkg::RESP_OKAY);
		end
		for (int i = 0; i < 11; i++) begin
			wr(fpl_pkg::OFF_CTRL, {23'h0, cv[i]}, fpl_pkg::RESP_OKAY);
			repeat (2) @(posedge aclk);
			look(con[i], cbl[i]);
		end
		stop <= 1'b1;
		repeat (6) @(posedge aclk);
		look(5'h02, 5'h19);
		stop <= 1'b0;
		wr(fpl_pkg::OFF_CTRL, 32'h101, fpl_pkg::RESP_OKAY);
		repeat (6) @(posedge aclk);
		press();
		look(5'h01, 5'h1C);
		wr(fpl_pkg::OFF_DUMP, 32'h1, fpl_pkg::RESP_OKAY);
		@(posedge aclk);
		look(5'h1C, 5'h00);
		repeat (20) @(posedge aclk);
		look(5'h01, 5'h00);
		wr(fpl_pkg::OFF_CTRL, 32'h100, fpl_pkg::RESP_OKAY);
		press();
		wr(fpl_pkg::OFF_DUMP, 32'h3, fpl_pkg::RESP_OKAY);
		@(posedge aclk);
		look(5'h1D, 5'h00);
		// Status word in the failure hold, then the press flag cleared
		rd(fpl_pkg::OFF_STAT, 32'h0000_017D, fpl_pkg::RESP_OKAY);
		wr(fpl_pkg::OFF_STAT, 32'h0000_0100, fpl_pkg::RESP_OKAY);
		rd(fpl_pkg::OFF_STAT, 32'h0000_0000, fpl_pkg::RESP_OKAY);
		conclude();
	end
endmodule
